// >>> sim/rtr_chan_model.sv
// rtr_chan_model: control-channel sink for translated requests.
// assumes fwd outputs held until ready; stalls stall_i cycles.
`timescale 1ns/1ps
`default_nettype none
module rtr_chan_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // forward side
  input  wire logic       fwd_valid_i,
  input  wire logic [1:0] stall_i,
  output logic            fwd_ready_o
);
  logic [1:0] wait_ff;
  // one-cycle ready after the stall; a slow channel is always legal
  always_ff @(posedge clk_i) begin
    if (rst_i || !fwd_valid_i || fwd_ready_o) begin
      wait_ff     <= 2'h0;
      fwd_ready_o <= 1'b0;
    end else begin
      wait_ff     <= wait_ff + 2'h1;
      fwd_ready_o <= (wait_ff >= stall_i);
    end
  end
endmodule : rtr_chan_model
`default_nettype wire

// >>> sim/rtr_remap_props.sv
// rtr_remap_props: port assertions for the remap block.
// assumes ce_i high and a master that holds requests until ack.
`timescale 1ns/1ps
`default_nettype none
module rtr_remap_props (
  // observed ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic        fwd_valid_o,
  input wire logic [6:0]  fwd_addr_o,
  input wire logic        fwd_ready_i,
  input wire logic        drop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  a_resv_bit_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[11:4] == 8'h1c
    |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[0])
    else $error("entry read not clean");
  a_answer_two_late: assert property (
    req_valid_i && req_ready_o |-> ##2 (fwd_valid_o ^ drop_o))
    else $error("no answer two cycles after take");
  a_fwd_after_take: assert property (
    $rose(fwd_valid_o) |-> $past(req_valid_i && req_ready_o, 2))
    else $error("forward without a lookup");
  a_fwd_hold: assert property (
    fwd_valid_o && !fwd_ready_i |=> fwd_valid_o && $stable(fwd_addr_o))
    else $error("forward not held");
  // a dropped request frees the engine at least one cycle sooner than a forward
  a_busy_refused: assert property (
    req_valid_i && req_ready_o |=> !req_ready_o [*2])
    else $error("ready during lookup");
  a_busy_while_fwd: assert property (
    fwd_valid_o |-> !req_ready_o)
    else $error("ready while a forward is pending");
  a_drop_no_fwd: assert property (
    drop_o |-> !fwd_valid_o ##1 !drop_o && !fwd_valid_o)
    else $error("dropped request forwarded");
  a_reset_quiet: assert property (
    disable iff (1'b0) rst_i |=> !wb_ack_o && !fwd_valid_o && !drop_o)
    else $error("outputs active after reset");
endmodule : rtr_remap_props
bind rtr_remap rtr_remap_props chk_u (.*);
`default_nettype wire

// >>> sim/tb_rtr_remap.sv
// tb_rtr_remap: self-checking bench for the remap block.
// assumes rtr_chan_model as sink and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_rtr_remap;
  import rtr_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc   = 0;
  logic        we    = 0;
  logic [11:0] adr   = 0;
  logic [31:0] dat   = 0;
  logic [31:0] dat_o;
  logic        ack, rv = 0, rp = 0, rdy, fv, fp, fl, frdy, drop;
  logic [6:0]  ra = 0, fa;
  logic [1:0]  stall = 0;
  logic [3:0]  sel   = 0;
  logic [3:0]  bsel  = 4'h1;
  logic [6:0]  al0 [4] = '{7'h11, 7'h12, 7'h13, 7'h14};
  logic [6:0]  al1 [4] = '{7'h21, 7'h22, 7'h23, 7'h24};
  logic [6:0]  e [2][4];
  logic [31:0] rdq [$];
  logic [31:0] fq [$];
  int          n_mismatch = 0, num_checks = 0, cnt = 0;

  rtr_remap dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .alias_p0_i(al0), .alias_p1_i(al1), .req_valid_i(rv),
    .req_port_i(rp), .req_addr_i(ra), .req_ready_o(rdy),
    .fwd_valid_o(fv), .fwd_port_o(fp), .fwd_addr_o(fa),
    .fwd_local_o(fl), .fwd_ready_i(frdy), .drop_o(drop));
  rtr_chan_model chan_u (.clk_i(clk_i), .rst_i(rst_i), .fwd_valid_i(fv),
    .stall_i(stall), .fwd_ready_o(frdy));

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request held until the ack edge, then low for a cycle
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= bsel;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rd(logic [11:0] a, logic [31:0] x);
    rdq.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic send(logic p, logic [6:0] a, logic [31:0] x);
    fq.push_back(x);
    stall <= 2'($urandom_range(0, 3));
    rv    <= 1'b1;
    rp    <= p;
    ra    <= a;
    @(posedge clk_i);
    while (rdy !== 1'b1) @(posedge clk_i);
    rv <= 1'b0;
    @(posedge clk_i);
  endtask : send
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // watcher: results are compared against the oldest note
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (ack === 1'b1 && !we) chk("rdata", dat_o, rdq.pop_front());
    if (fv === 1'b1 && frdy === 1'b1)
      chk("fwd", {22'h0, 1'b0, fl, fp, fa}, fq.pop_front());
    if (drop === 1'b1) chk("drop", 32'h200, fq.pop_front());
    if (cnt == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(39805));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(12'h1c0 + 12'(4 * i), 32'h0);
    rd(12'h004, RTR_UNMAPPED_DATA);
    $display("test reset values done");
    // program both ports with the reserved bit set; one entry disabled
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 12'h1bc, 32'(p));
      for (int i = 0; i < 4; i++) begin
        e[p][i] = (p == 0 && i == 2) ? 7'h00 : 7'($urandom_range(1, 127));
        bus(1'b1, 12'h1c0 + 12'(4 * i), {24'h0, e[p][i], 1'b1});
      end
    end
    for (int p = 1; p >= 0; p--) begin
      bus(1'b1, 12'h1bc, 32'(p));
      for (int i = 0; i < 4; i++)
        rd(12'h1c0 + 12'(4 * i), {24'h0, e[p][i], 1'b0});
    end
    // a write without the low byte enable must leave the entry alone
    bsel = 4'h0;
    bus(1'b1, 12'h1c0, 32'h0000_00fe);
    bsel = 4'h1;
    rd(12'h1c0, {24'h0, e[0][0], 1'b0});
    $display("test port tables done");
    // every alias on both ports, then an address no alias claims
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++)
        send(1'(p), p ? al1[i] : al0[i], e[p][i] == 7'h00 ? 32'h200 :
          {22'h0, 2'b00, 1'(p), e[p][i]});
    end
    send(1'b0, 7'h55, {22'h0, 2'b01, 1'b0, 7'h55});
    while (fq.size() != 0) @(posedge clk_i);
    // seven hits and one pass-through went out; the dropped one did not
    rd(12'h1b8, 32'h0000_0008);
    $display("test translation done");
    // reset in mid-run clears the tables again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h1c0, 32'h0);
    rd(12'h1b8, 32'h0);
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb_rtr_remap
`default_nettype wire

// >>> verilog/rtr_match.sv
// rtr_match: combinational alias lookup over one port's remap table.
// assumes the table is stable while a lookup is registered.
`timescale 1ns/1ps
`default_nettype none
module rtr_match
  import rtr_pkg::*;
#(
  parameter int ENTRIES = RTR_ENTRIES
) (
  // table
  rtr_tbl_if.user   tbl,
  // lookup
  input  wire logic [6:0] addr_i,
  output logic            hit_o,
  output logic            passthru_o,
  output logic [6:0]      addr_o
);
  logic [ENTRIES-1:0] alias_hit;
  logic [ENTRIES-1:0] hit_vec;

  // per-entry compare; a zero real address disables the entry
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    assign alias_hit[g] = (tbl.alias_addr[g] == addr_i) &&
                          (tbl.alias_addr[g] != RTR_ALIAS_RESET);
    assign hit_vec[g]   = alias_hit[g] &&
                          (tbl.real_addr[g] != 7'h00);
  end

  // lowest enabled entry wins when aliases collide
  always_comb begin
    hit_o  = 1'b0;
    addr_o = addr_i;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_o  = 1'b1;
        addr_o = tbl.real_addr[i];
      end
    end
    passthru_o = ~|alias_hit;
  end
endmodule : rtr_match
`default_nettype wire

// >>> verilog/rtr_pkg.sv
// rtr_pkg: constants for the remote target address remap block.
// assumes a wishbone classic register bus with 32-bit data.
`default_nettype none
package rtr_pkg;
  // printed register offsets are indices; byte address is four times index
  localparam logic [7:0] RTR_IDX_TGT_ONE   = 8'h70;
  localparam logic [7:0] RTR_IDX_TGT_TWO   = 8'h71;
  localparam logic [7:0] RTR_IDX_TGT_THREE = 8'h72;
  localparam logic [7:0] RTR_IDX_TGT_FOUR  = 8'h73;
  // control register holding the port select bit
  localparam logic [7:0] RTR_IDX_CTRL      = 8'h6f;
  // status register of the lookup engine
  localparam logic [7:0] RTR_IDX_STAT      = 8'h6e;
  localparam int         RTR_CTRL_PSEL_BIT = 0;
  localparam int         RTR_ADDR_MSB      = 7;
  localparam int         RTR_ADDR_LSB      = 1;
  localparam logic [7:0] RTR_TGT_RESET     = 8'h00;
  localparam logic [6:0] RTR_ALIAS_RESET   = 7'h00;
  localparam int         RTR_ENTRIES       = 4;
  localparam int         RTR_PORTS         = 2;
  localparam logic [31:0] RTR_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    RTR_IDLE = 3'b001,
    RTR_LOOK = 3'b010,
    RTR_SEND = 3'b100
  } rtr_state_type;
endpackage : rtr_pkg
`default_nettype wire

// >>> verilog/rtr_remap.sv
// rtr_remap: remote target address remap with wishbone register access.
// assumes a local i2c front end that offers one address per transaction
// and a control-channel sender that accepts one translated address.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each entry keeps a 7-bit real target address in bits 7:1; bit 0 reserved.
// - a transaction to entry N's alias gets entry N's real address.
// - the translated transaction goes to the control channel only after substitution.
// - an entry holding zero blocks its alias; nothing is forwarded for it.
// - with second port select set, entry accesses hit the second port's table.
module rtr_remap
  import rtr_pkg::*;
#(
  parameter int ENTRIES = RTR_ENTRIES
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // alias table, from the alias registers kept elsewhere
  input  wire logic [6:0]  alias_p0_i [ENTRIES],
  input  wire logic [6:0]  alias_p1_i [ENTRIES],
  // transaction request from the local i2c front end
  input  wire logic        req_valid_i,
  input  wire logic        req_port_i,
  input  wire logic [6:0]  req_addr_i,
  output logic             req_ready_o,
  // translated request to the control channel
  output logic             fwd_valid_o,
  output logic             fwd_port_o,
  output logic [6:0]       fwd_addr_o,
  output logic             fwd_local_o,
  input  wire logic        fwd_ready_i,
  // transaction dropped because its alias is disabled
  output logic             drop_o
);
  rtr_tbl_if #(.ENTRIES(ENTRIES)) tbl_p0 ();
  rtr_tbl_if #(.ENTRIES(ENTRIES)) tbl_p1 ();

  // register state
  logic [6:0]  tgt_ff     [RTR_PORTS][ENTRIES];
  logic [6:0]  nxt_tgt    [RTR_PORTS][ENTRIES];
  logic        psel_ff;
  logic        nxt_psel;
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;

  // engine state
  rtr_state_type st_ff;
  rtr_state_type nxt_st;
  logic        port_ff;
  logic        nxt_port;
  logic [6:0]  addr_ff;
  logic [6:0]  nxt_addr;
  logic        fv_ff;
  logic        nxt_fv;
  logic        fl_ff;
  logic        nxt_fl;
  logic [6:0]  fa_ff;
  logic [6:0]  nxt_fa;
  logic        drop_ff;
  logic        nxt_drop;
  logic        rdy_ff;
  logic        nxt_rdy;
  logic [31:0] fwd_cnt_ff;
  logic [31:0] nxt_fwd_cnt;

  // lookup results
  logic        hit0;
  logic        hit1;
  logic        pass0;
  logic        pass1;
  logic [6:0]  maddr0;
  logic [6:0]  maddr1;

  // bus decode
  logic        wb_req;
  logic [9:0]  wb_idx;
  logic        ent_sel;
  logic [1:0]  ent_num;

  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_idx  = wb_adr_i[11:2];
  assign ent_sel = (wb_idx[9:8] == 2'b00) && (wb_idx[7:2] == RTR_IDX_TGT_ONE[7:2]);
  assign ent_num = wb_idx[1:0];

  // drive the per-port tables
  for (genvar g = 0; g < ENTRIES; g++) begin : g_tbl
    assign tbl_p0.real_addr[g]  = tgt_ff[0][g];
    assign tbl_p1.real_addr[g]  = tgt_ff[1][g];
    assign tbl_p0.alias_addr[g] = alias_p0_i[g];
    assign tbl_p1.alias_addr[g] = alias_p1_i[g];
  end

  rtr_match #(.ENTRIES(ENTRIES)) u_match0 (
    .tbl        (tbl_p0.user),
    .addr_i     (addr_ff),
    .hit_o      (hit0),
    .passthru_o (pass0),
    .addr_o     (maddr0)
  );

  rtr_match #(.ENTRIES(ENTRIES)) u_match1 (
    .tbl        (tbl_p1.user),
    .addr_i     (addr_ff),
    .hit_o      (hit1),
    .passthru_o (pass1),
    .addr_o     (maddr1)
  );

  // register next state; answers in one cycle, unmapped reads give zero
  always_comb begin
    nxt_tgt  = tgt_ff;
    nxt_psel = psel_ff;
    nxt_ack  = 1'b0;
    nxt_rdat = RTR_UNMAPPED_DATA;
    if (wb_req) begin
      nxt_ack = 1'b1;
      if (ent_sel) begin
        // port select steers both reads and writes of entries
        nxt_rdat[RTR_ADDR_MSB:RTR_ADDR_LSB] =
          tgt_ff[psel_ff][ent_num];
        if (wb_we_i && wb_sel_i[0]) begin
          nxt_tgt[psel_ff][ent_num] =
            wb_dat_i[RTR_ADDR_MSB:RTR_ADDR_LSB];
        end
      end else if (wb_idx == {2'b00, RTR_IDX_CTRL}) begin
        nxt_rdat[RTR_CTRL_PSEL_BIT] = psel_ff;
        if (wb_we_i && wb_sel_i[0]) begin
          nxt_psel = wb_dat_i[RTR_CTRL_PSEL_BIT];
        end
      end else if (wb_idx == {2'b00, RTR_IDX_STAT}) begin
        nxt_rdat = fwd_cnt_ff; // forwarded transaction count
      end
    end
  end

  // register state flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < RTR_PORTS; p++) begin
        for (int e = 0; e < ENTRIES; e++) begin
          tgt_ff[p][e] <= RTR_TGT_RESET[RTR_ADDR_MSB:RTR_ADDR_LSB];
        end
      end
      psel_ff <= 1'b0;
      ack_ff  <= 1'b0;
      rdat_ff <= RTR_UNMAPPED_DATA;
    end else if (ce_i) begin
      tgt_ff  <= nxt_tgt;
      psel_ff <= nxt_psel;
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // engine: take address, look up, then offer the translated one
  always_comb begin
    nxt_st      = st_ff;
    nxt_port    = port_ff;
    nxt_addr    = addr_ff;
    nxt_fv      = fv_ff;
    nxt_fl      = fl_ff;
    nxt_fa      = fa_ff;
    nxt_drop    = 1'b0;
    nxt_rdy     = 1'b0;
    nxt_fwd_cnt = fwd_cnt_ff;
    unique case (st_ff)
      RTR_IDLE: begin
        nxt_rdy = 1'b1;
        if (req_valid_i && rdy_ff) begin
          nxt_port = req_port_i;
          nxt_addr = req_addr_i;
          nxt_rdy  = 1'b0;
          nxt_st   = RTR_LOOK;
        end
      end
      RTR_LOOK: begin
        // substitution settles here, before anything is offered
        if (port_ff ? (hit1 || pass1) : (hit0 || pass0)) begin
          nxt_fa = port_ff ? maddr1 : maddr0;
          nxt_fl = port_ff ? pass1 : pass0;
          nxt_fv = 1'b1;
          nxt_st = RTR_SEND;
        end else begin
          nxt_drop = 1'b1;
          nxt_st   = RTR_IDLE;
        end
      end
      RTR_SEND: begin
        if (fwd_ready_i) begin
          nxt_fv      = 1'b0;
          nxt_st      = RTR_IDLE;
          nxt_fwd_cnt = fwd_cnt_ff + 32'h0000_0001;
        end
      end
    endcase
  end

  // engine flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff      <= RTR_IDLE;
      port_ff    <= 1'b0;
      addr_ff    <= 7'h00;
      fv_ff      <= 1'b0;
      fl_ff      <= 1'b0;
      fa_ff      <= 7'h00;
      drop_ff    <= 1'b0;
      rdy_ff     <= 1'b0;
      fwd_cnt_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      st_ff      <= nxt_st;
      port_ff    <= nxt_port;
      addr_ff    <= nxt_addr;
      fv_ff      <= nxt_fv;
      fl_ff      <= nxt_fl;
      fa_ff      <= nxt_fa;
      drop_ff    <= nxt_drop;
      rdy_ff     <= nxt_rdy;
      fwd_cnt_ff <= nxt_fwd_cnt;
    end
  end

  // outputs straight from flops
  assign wb_ack_o    = ack_ff;
  assign wb_dat_o    = rdat_ff;
  assign req_ready_o = rdy_ff;
  assign fwd_valid_o = fv_ff;
  assign fwd_port_o  = port_ff;
  assign fwd_addr_o  = fa_ff;
  assign fwd_local_o = fl_ff;
  assign drop_o      = drop_ff;
endmodule : rtr_remap
`default_nettype wire

// >>> verilog/rtr_tbl_if.sv
// rtr_tbl_if: carries the remap table of one port between modules.
// assumes one clock; the table holds plain levels.
`timescale 1ns/1ps
`default_nettype none
interface rtr_tbl_if #(
  parameter int ENTRIES = 4
);
  logic [6:0] real_addr [ENTRIES];
  logic [6:0] alias_addr [ENTRIES];
  modport owner (output real_addr, output alias_addr);
  modport user  (input real_addr, input alias_addr);
endinterface : rtr_tbl_if
`default_nettype wire
